// ---- verilog/spimp_pin_if.sv ----
// Contract
// - 4K sectors, eight 512-byte pages each
// - lane1 changes on serial clock falling edge
// - lane1 keeps driving in dual/quad reads
// - lane1 high impedance while deselected
// - input lane sampled on rising edge
// - input lane becomes output in dual/quad
// - input lane undriven while deselected
// - all bytes shifted most significant first
// - arm on select fall, end on rise
// - quad lanes 2,3 output after address
//
// Purpose: pin-level shift engine of a serial page memory
// Assumes: link clock is far slower than clk_sys (8+ cycles per half period)
// Notes: command decoding sits upstream and steers lane_mode and out_en
`timescale 1ns/100ps
module spimp_pin_if
	import spimp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// link clock and select
	input wire logic sclk_pin,
	input wire logic select_n_pin,
	// lane 0, input in single mode
	input wire logic serial_in_lane0_i,
	output logic serial_in_lane0_o,
	output logic serial_in_lane0_oe_n,
	// lane 1, output only
	output logic serial_out_lane1_o,
	output logic serial_out_lane1_oe_n,
	// lanes 2 and 3, write-protect and pause levels when not outputs
	input wire logic data_lane_two_i,
	output logic data_lane_two_o,
	output logic data_lane_two_oe_n,
	input wire logic data_lane_three_i,
	output logic data_lane_three_o,
	output logic data_lane_three_oe_n,
	// frame status
	output logic frame_active,
	output logic frame_start,
	output logic frame_end,
	// received bytes
	output spimp_rx_type rx_word,
	output logic rx_valid,
	output spimp_addr_type rx_addr,
	output logic rx_addr_valid,
	// transmit side
	input wire spimp_mode_type lane_mode,
	input wire logic out_en,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	// sampled control pins
	output logic protect_level,
	output logic pause_level
);

	// ==========================================================
	// pin synchronisers
	logic [4:0] pins_s;
	logic sclk_s;
	logic sel_n_s;
	logic din_s;

	spimp_sync #(
		.WIDTH(5)
	) u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in({sclk_pin, select_n_pin, serial_in_lane0_i, data_lane_two_i,
			data_lane_three_i}),
		.sync_out(pins_s)
	);

	assign sclk_s = pins_s[4];
	assign sel_n_s = pins_s[3];
	assign din_s = pins_s[2];
	assign protect_level = pins_s[1];
	assign pause_level = pins_s[0];

	// ==========================================================
	// edge detection
	logic sclk_prev_q;
	logic sel_prev_q;
	logic clk_rise;
	logic clk_fall;
	logic sel_fall;
	logic sel_rise;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sclk_prev_q <= 1'b0;
			sel_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
			sel_prev_q <= sel_n_s;
		end
	end

	assign clk_rise = sclk_s & ~sclk_prev_q;
	assign clk_fall = ~sclk_s & sclk_prev_q;
	assign sel_fall = sel_prev_q & ~sel_n_s;
	assign sel_rise = ~sel_prev_q & sel_n_s;

	// ==========================================================
	// frame state
	spimp_state_type state_q;
	spimp_state_type state_d;
	logic start_d;
	logic start_q;
	logic end_d;
	logic end_q;
	logic active;

	always_comb begin
		state_d = state_q;
		start_d = 1'b0;
		end_d = 1'b0;
		unique case (state_q)
			ST_WAIT_ARM, ST_IDLE: begin
				if (sel_fall) begin
					state_d = ST_ACTIVE;
					start_d = 1'b1;
				end
			end
			ST_ACTIVE: begin
				if (sel_rise) begin
					state_d = ST_IDLE;
					end_d = 1'b1;
				end
			end
			default: state_d = ST_WAIT_ARM;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q <= ST_WAIT_ARM;
			start_q <= 1'b0;
			end_q <= 1'b0;
		end else begin
			state_q <= state_d;
			start_q <= start_d;
			end_q <= end_d;
		end
	end

	// a level-low select seen at reset release is not a frame
	assign active = (state_q == ST_ACTIVE) && !sel_n_s;
	assign frame_active = (state_q == ST_ACTIVE);
	assign frame_start = start_q;
	assign frame_end = end_q;

	// ==========================================================
	// receive shifter
	logic [7:0] rx_sh_q;
	logic [7:0] rx_sh_d;
	logic [2:0] rx_bit_q;
	logic [2:0] rx_bit_d;
	logic [2:0] byte_cnt_q;
	logic [2:0] byte_cnt_d;
	logic [23:0] addr_sh_q;
	logic [23:0] addr_sh_d;
	spimp_rx_type rx_word_q;
	spimp_rx_type rx_word_d;
	logic rx_valid_q;
	logic rx_valid_d;
	logic addr_valid_q;
	logic addr_valid_d;
	logic lane0_drive;

	always_comb begin
		rx_sh_d = rx_sh_q;
		rx_bit_d = rx_bit_q;
		byte_cnt_d = byte_cnt_q;
		addr_sh_d = addr_sh_q;
		rx_word_d = rx_word_q;
		rx_valid_d = 1'b0;
		addr_valid_d = 1'b0;
		if (!active) begin
			rx_bit_d = 3'h0;
			byte_cnt_d = 3'h0;
		end else if (clk_rise && !lane0_drive) begin
			rx_sh_d = {rx_sh_q[6:0], din_s};
			rx_bit_d = rx_bit_q + 3'h1;
			if (rx_bit_q == 3'h7) begin
				rx_valid_d = 1'b1;
				rx_word_d.data = rx_sh_d;
				rx_word_d.index = byte_cnt_q;
				if (byte_cnt_q != QUAD_LANE_BYTE) begin
					byte_cnt_d = byte_cnt_q + 3'h1;
				end
				if (byte_cnt_q != 3'h0 && byte_cnt_q <= ADDR_LAST_BYTE) begin
					addr_sh_d = {addr_sh_q[15:0], rx_sh_d};
					addr_valid_d = (byte_cnt_q == ADDR_LAST_BYTE);
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rx_sh_q <= 8'h00;
			rx_bit_q <= 3'h0;
			byte_cnt_q <= 3'h0;
			addr_sh_q <= 24'h000000;
			rx_word_q <= '0;
			rx_valid_q <= 1'b0;
			addr_valid_q <= 1'b0;
		end else begin
			rx_sh_q <= rx_sh_d;
			rx_bit_q <= rx_bit_d;
			byte_cnt_q <= byte_cnt_d;
			addr_sh_q <= addr_sh_d;
			rx_word_q <= rx_word_d;
			rx_valid_q <= rx_valid_d;
			addr_valid_q <= addr_valid_d;
		end
	end

	assign rx_word = rx_word_q;
	assign rx_valid = rx_valid_q;
	assign rx_addr_valid = addr_valid_q;

	assign rx_addr.sector = addr_sh_q[ADDR_BITS-1:SECTOR_LSB];
	assign rx_addr.page = addr_sh_q[SECTOR_LSB-1:PAGE_LSB];
	assign rx_addr.offset = addr_sh_q[PAGE_LSB-1:0];

	// ==========================================================
	// transmit shifter
	logic [7:0] tx_sh_q;
	logic [7:0] tx_sh_d;
	logic [3:0] tx_left_q;
	logic [3:0] tx_left_d;
	logic [3:0] lane_q;
	logic [3:0] lane_d;
	logic [3:0] drive_q;
	logic [3:0] drive_d;
	logic [7:0] word;
	logic [3:0] step;
	logic quad_ok;

	assign quad_ok = (lane_mode == MODE_QUAD) && (byte_cnt_q == QUAD_LANE_BYTE);
	assign tx_ready = active && out_en && clk_fall && (tx_left_q == 4'h0);
	assign lane0_drive = drive_q[0];

	always_comb begin
		tx_sh_d = tx_sh_q;
		tx_left_d = tx_left_q;
		lane_d = lane_q;
		drive_d = 4'h0;
		word = (tx_left_q == 4'h0) ? tx_data : tx_sh_q;
		unique case (lane_mode)
			MODE_DUAL: step = 4'h2;
			MODE_QUAD: step = 4'h4;
			default: step = 4'h1;
		endcase
		if (!active) begin
			tx_left_d = 4'h0;
		end else begin
			drive_d[1] = 1'b1;
			drive_d[0] = out_en && (lane_mode != MODE_SINGLE);
			drive_d[3:2] = {2{out_en && quad_ok}};
			if (out_en && clk_fall) begin
				unique case (lane_mode)
					MODE_DUAL: lane_d = {2'b00, word[7], word[6]};
					MODE_QUAD: lane_d = word[7:4];
					default: lane_d = {2'b00, word[7], 1'b0};
				endcase
				tx_sh_d = word << step;
				tx_left_d = ((tx_left_q == 4'h0) ? BYTE_BITS_4 : tx_left_q) - step;
			end else if (!out_en) begin
				tx_left_d = 4'h0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_sh_q <= 8'h00;
			tx_left_q <= 4'h0;
			lane_q <= 4'h0;
			drive_q <= 4'h0;
		end else begin
			tx_sh_q <= tx_sh_d;
			tx_left_q <= tx_left_d;
			lane_q <= lane_d;
			drive_q <= drive_d;
		end
	end

	// ==========================================================
	// pin drivers, enables low while driving
	assign serial_in_lane0_o = lane_q[0];
	assign serial_out_lane1_o = lane_q[1];
	assign data_lane_two_o = lane_q[2];
	assign data_lane_three_o = lane_q[3];
	assign serial_in_lane0_oe_n = ~drive_q[0];
	assign serial_out_lane1_oe_n = ~drive_q[1];
	assign data_lane_two_oe_n = ~drive_q[2];
	assign data_lane_three_oe_n = ~drive_q[3];

endmodule : spimp_pin_if

// ---- verilog/spimp_pkg.sv ----
// Purpose: shared constants and carriers for the serial memory pin interface
// Assumes: one system clock, link pins sampled through two flip-flops
// Notes: address layout is 4-Kbyte sectors of eight 512-byte pages
package spimp_pkg;

	// ==========================================================
	// memory organisation
	localparam int ADDR_BITS = 24;
	localparam logic [23:0] SECTOR_BYTES = 24'h001000;
	localparam logic [23:0] PAGE_BYTES = 24'h000200;
	localparam int SECTOR_LSB = 12;
	localparam int PAGE_LSB = 9;
	localparam int PAGES_PER_SECTOR = 8;

	// ==========================================================
	// framing
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] BYTE_BITS_4 = 4'h8;
	localparam logic [2:0] ADDR_LAST_BYTE = 3'h3;
	localparam logic [2:0] QUAD_LANE_BYTE = 3'h4;
	localparam int SYNC_STAGES = 2;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		MODE_SINGLE = 3'b001,
		MODE_DUAL = 3'b010,
		MODE_QUAD = 3'b100
	} spimp_mode_type;

	typedef enum logic [2:0] {
		ST_WAIT_ARM = 3'b001,
		ST_IDLE = 3'b010,
		ST_ACTIVE = 3'b100
	} spimp_state_type;

	typedef struct packed {
		logic [7:0] data;
		logic [2:0] index;
	} spimp_rx_type;

	typedef struct packed {
		logic [ADDR_BITS-SECTOR_LSB-1:0] sector;
		logic [SECTOR_LSB-PAGE_LSB-1:0] page;
		logic [PAGE_LSB-1:0] offset;
	} spimp_addr_type;

endpackage : spimp_pkg

// ---- verilog/spimp_sync.sv ----
// Purpose: two-stage level synchroniser for link pins
// Assumes: inputs are asynchronous to clk_sys
// Notes: the first stage feeds only the second
`timescale 1ns/100ps
module spimp_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule : spimp_sync

// ---- tb/spimp_pin_if_chk.sv ----
// Purpose: port checks of spimp_pin_if
// Assumes: link half period far above sync delay
// Notes: bound to the design below
`timescale 1ns/100ps
module spimp_pin_if_chk
	import spimp_pkg::*;
(
	// system
	input wire logic clk_sys,
	input wire logic reset,
	// pins and user side
	input wire logic sclk_pin,
	input wire logic select_n_pin,
	input wire logic serial_in_lane0_oe_n,
	input wire logic serial_out_lane1_o,
	input wire logic serial_out_lane1_oe_n,
	input wire logic data_lane_two_oe_n,
	input wire logic data_lane_three_oe_n,
	input wire logic frame_active,
	input wire logic frame_start,
	input wire logic frame_end,
	input wire spimp_rx_type rx_word,
	input wire logic rx_valid,
	input wire logic rx_addr_valid,
	input wire spimp_mode_type lane_mode,
	input wire logic out_en
);
	// ========
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_lane1_idle: assert property (select_n_pin [*6] |-> serial_out_lane1_oe_n)
		else $error("lane1 driven while deselected");
	chk_lane0_idle: assert property (select_n_pin [*6] |-> serial_in_lane0_oe_n)
		else $error("lane0 driven while deselected");
	chk_lane1_fall: assert property ($changed(serial_out_lane1_o) && out_en &&
		$past(out_en) |-> !sclk_pin) else $error("lane1 moved with clock high");
	chk_start_arm: assert property ($rose(frame_active) |-> frame_start && !select_n_pin)
		else $error("frame began without select fall");
	chk_end_release: assert property (frame_end |-> ##[0:2] serial_out_lane1_oe_n &&
		serial_in_lane0_oe_n && data_lane_two_oe_n && data_lane_three_oe_n)
		else $error("lanes kept after end");
	chk_quad_only: assert property (!data_lane_two_oe_n || !data_lane_three_oe_n |->
		$past(lane_mode) == MODE_QUAD && $past(out_en)) else $error("upper lanes driven");
	chk_dual_lane0: assert property (!serial_in_lane0_oe_n |->
		$past(out_en) && $past(lane_mode) != MODE_SINGLE) else $error("lane0 driven");
	chk_addr_index: assert property (rx_addr_valid |-> rx_valid &&
		rx_word.index == ADDR_LAST_BYTE) else $error("address not with byte 3");
endmodule : spimp_pin_if_chk

bind spimp_pin_if spimp_pin_if_chk i_chk (.clk_sys, .reset, .sclk_pin, .select_n_pin,
	.serial_in_lane0_oe_n, .serial_out_lane1_o, .serial_out_lane1_oe_n, .data_lane_two_oe_n,
	.data_lane_three_oe_n, .frame_active, .frame_start, .frame_end, .rx_word, .rx_valid,
	.rx_addr_valid, .lane_mode, .out_en);

// ---- tb/spimp_host.sv ----
// Purpose: link host model for spimp_pin_if
// Assumes: 8 clk_sys cycles a half period
// Notes: cpol picks mode 0,0 or 1,1
`timescale 1ns/100ps
module spimp_host (
	// system
	input wire logic clk_sys,
	// link
	input wire logic [3:0] lanes,
	output logic sclk_pin,
	output logic select_n_pin,
	output logic mosi,
	output logic mosi_oe_n
);
	logic cpol = 1'b0;
	initial begin
		sclk_pin = 1'b0;
		select_n_pin = 1'b1;
		mosi = 1'b0;
		mosi_oe_n = 1'b1;
	end
	task automatic tick;
		repeat (8) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic frame(input logic on);
		sclk_pin = cpol;
		tick;
		select_n_pin = !on;
		mosi_oe_n = !on;
		tick;
	endtask : frame
	task automatic xfer(input logic [7:0] tx, input int w, input int n, output logic [7:0] rx);
		rx = 8'h00;
		mosi_oe_n = w > 1;
		for (int i = 0; i < n; i++) begin
			sclk_pin = 1'b0;
			mosi = tx[7 - i];
			tick;
			sclk_pin = 1'b1;
			rx = w == 4 ? {rx[3:0], lanes} : w == 2 ? {rx[5:0], lanes[1:0]} : {rx[6:0], lanes[1]};
			tick;
		end
	endtask : xfer
endmodule : spimp_host

// ---- tb/tb.sv ----
// Purpose: self-checking bench of spimp_pin_if
// Assumes: 100 MHz clk_sys, 160 ns link clock
// Notes: rows cover every lane mode and both idle levels
`timescale 1ns/100ps
module tb
	import spimp_pkg::*;
;
	typedef struct {spimp_mode_type m; logic cpol; logic [23:0] a; int n;} spimp_row_type;
	spimp_row_type rows[3] = '{'{MODE_SINGLE, 1'b0, 24'h001FFF, 2},
		'{MODE_DUAL, 1'b1, 24'h000E00, 2}, '{MODE_QUAD, 1'b0, 24'hFFF000, 3}};
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [3:0] lanes;
	logic [3:0] last = 4'h0;
	// write-protect and pause levels that the far side holds on lanes 2 and 3
	logic wp_lvl = 1'b1;
	logic hold_lvl = 1'b1;
	logic sclk_pin, select_n_pin, mosi, mosi_oe_n, frame_active, rx_valid, tx_ready;
	logic frame_start, frame_end, rx_addr_valid, protect_level, pause_level;
	int n_start = 0;
	int n_end = 0;
	int n_addr = 0;
	logic l0_o, l0_oe_n, l1_o, l1_oe_n, l2_o, l2_oe_n, l3_o, l3_oe_n;
	logic out_en = 1'b0;
	logic [7:0] tx_data = 8'hA5;
	logic [7:0] rx;
	spimp_rx_type rx_word;
	spimp_addr_type rx_addr;
	spimp_mode_type lane_mode = MODE_SINGLE;
	logic [7:0] got[$];
	int fail_count = 0;
	int n_checks = 0;

	always #5 clk_sys = ~clk_sys;
	// lanes 0 and 1 show the inverse of their last level when no side drives them, lanes 2 and 3 the far-side levels
	assign lanes[0] = !l0_oe_n ? l0_o : !mosi_oe_n ? mosi : ~last[0];
	assign lanes[1] = !l1_oe_n ? l1_o : ~last[1];
	assign lanes[2] = !l2_oe_n ? l2_o : wp_lvl;
	assign lanes[3] = !l3_oe_n ? l3_o : hold_lvl;
	always @(posedge clk_sys) begin
		last <= lanes;
		if (frame_start === 1'b1) n_start <= n_start + 1;
		if (frame_end === 1'b1) n_end <= n_end + 1;
		if (rx_addr_valid === 1'b1) n_addr <= n_addr + 1;
		if (tx_ready === 1'b1) tx_data <= tx_data + 8'h11;
		if (rx_valid === 1'b1) got.push_back(rx_word.data);
	end

	spimp_host i_spimp_host (.clk_sys, .lanes, .sclk_pin, .select_n_pin, .mosi, .mosi_oe_n);
	spimp_pin_if i_spimp_pin_if (.clk_sys, .reset, .sclk_pin, .select_n_pin,
		.serial_in_lane0_i(lanes[0]), .serial_in_lane0_o(l0_o), .serial_in_lane0_oe_n(l0_oe_n),
		.serial_out_lane1_o(l1_o), .serial_out_lane1_oe_n(l1_oe_n),
		.data_lane_two_i(lanes[2]), .data_lane_two_o(l2_o), .data_lane_two_oe_n(l2_oe_n),
		.data_lane_three_i(lanes[3]), .data_lane_three_o(l3_o), .data_lane_three_oe_n(l3_oe_n),
		.frame_active, .frame_start, .frame_end, .rx_word, .rx_valid, .rx_addr,
		.rx_addr_valid, .lane_mode, .out_en, .tx_data, .tx_ready, .protect_level,
		.pause_level);

	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrap_up

	task automatic run(input spimp_row_type r);
		logic [31:0] h;
		logic [7:0] exp;
		h = {8'h3C, r.a};
		i_spimp_host.cpol = r.cpol;
		got.delete();
		i_spimp_host.frame(1'b1);
		for (int k = 0; k < 4; k++) i_spimp_host.xfer(h[31 - 8 * k -: 8], 1, 8, rx);
		for (int k = 0; k < 4; k++) chk("rx byte", got[k], h[31 - 8 * k -: 8]);
		chk("sector", rx_addr.sector, r.a[23:12]);
		chk("page", rx_addr.page, r.a[11:9]);
		lane_mode = r.m;
		out_en = 1'b1;
		exp = tx_data;
		for (int k = 0; k < r.n; k++) begin
			i_spimp_host.xfer(8'h00, int'(r.m), 8 / int'(r.m), rx);
			chk("read byte", rx, exp);
			exp = exp + 8'h11;
		end
		out_en = 1'b0;
		i_spimp_host.frame(1'b0);
		chk("enables", {l3_oe_n, l2_oe_n, l1_oe_n, l0_oe_n}, 4'hF);
		$display("frame in mode %0d done", r.m);
	endtask : run

	initial begin
		#1;
		i_spimp_host.select_n_pin = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		chk("reset state", {l3_oe_n, l2_oe_n, l1_oe_n, l0_oe_n, frame_active}, 5'h1E);
		i_spimp_host.xfer(8'h3C, 1, 8, rx);
		chk("unarmed bytes", got.size(), 0);
		i_spimp_host.frame(1'b0);
		$display("reset test done");
		// lanes 2 and 3 report their levels while they are not outputs
		wp_lvl = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk("pin levels", {protect_level, pause_level}, 2'b01);
		wp_lvl = 1'b1;
		hold_lvl = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk("pin levels", {protect_level, pause_level}, 2'b10);
		hold_lvl = 1'b1;
		$display("pin level test done");
		foreach (rows[i]) run(rows[i]);
		// a partial byte is dropped at select rise
		got.delete();
		i_spimp_host.frame(1'b1);
		i_spimp_host.xfer(8'hC3, 1, 4, rx);
		i_spimp_host.frame(1'b0);
		i_spimp_host.frame(1'b1);
		i_spimp_host.xfer(8'h5A, 1, 8, rx);
		i_spimp_host.frame(1'b0);
		chk("partial count", got.size(), 1);
		chk("after partial", got[0], 8'h5A);
		$display("partial byte test done");
		chk("frame starts", n_start, 5);
		chk("frame ends", n_end, 5);
		chk("address words", n_addr, 3);
		$display("pulse count test done");
		wrap_up;
	end
endmodule : tb
